// ---- logic/rcf_pkg.sv ----
//
// Overview of operation
// - Stack overflow sets flag bit 7; it stays set until firmware writes 0 or a brown-out clears it.
// - Stack underflow sets flag bit 6; it stays set until firmware writes 0 or a brown-out clears it.
// - Bits 5 and 4 are unimplemented: read zero, writes ignored.
// - A master-clear pin reset clears bit 3; firmware may write it back to 1.
// - The reset instruction clears bit 2; a firmware write of 1 re-arms it.
// - Power-on reset holds bit 1 at 0 until software writes 1.
// - Brown-out or power-on reset clears bit 0; it reads 1 only after a write of 1.
// - Power-on/brown-out: stack flags 0, pin and instruction flags 1; others per cause.
//
package rcf_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam int         ADDR_W       = 12;
   localparam logic [11:0] OFF_CAUSE    = 12'h000;
   localparam logic [11:0] OFF_IRQ_STAT = 12'h004;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h008;

   // ------------------------------------------------------------
   // Reset-cause field positions
   // ------------------------------------------------------------
   localparam int BIT_STACK_OVF = 7;
   localparam int BIT_STACK_UNF = 6;
   localparam int BIT_PIN_RST   = 3;
   localparam int BIT_RST_INSTR = 2;
   localparam int BIT_POWER_ON  = 1;
   localparam int BIT_BROWNOUT  = 0;

   // ------------------------------------------------------------
   // Reset values and per-bit behaviour masks
   // ------------------------------------------------------------
   localparam logic [7:0] CAUSE_IMPL_MASK = 8'hcf;
   localparam logic [7:0] CAUSE_POR_VAL   = 8'h0c;
   localparam logic [7:0] CAUSE_EVT_VAL   = 8'hc0;
   localparam logic [7:0] CAUSE_PWR_MASK  = 8'hcc;
   localparam logic [7:0] IRQ_IMPL_MASK   = 8'hcd;
   localparam logic [7:0] IRQ_MASK_RST    = 8'h00;
   localparam logic [7:0] IRQ_STAT_RST    = 8'h00;
   localparam logic [0:0] PIN_IDLE        = 1'h1;

endpackage : rcf_pkg

// ---- logic/rcf_flag_bit.sv ----
`timescale 1ns/1ps
// One reset-cause flag: its own event forces EVT_VAL, a power event forces
// PWR_VAL, and only then may a firmware write change it.
module rcf_flag_bit #(
   parameter logic POR_VAL = 1'b0,
   parameter logic EVT_VAL = 1'b0,
   parameter logic PWR_VAL = 1'b0,
   parameter bit   USE_PWR = 1'b0
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic nrst,
   // Hardware events
   input  wire logic own_evt,
   input  wire logic pwr_evt,
   // Firmware write
   input  wire logic wr_en,
   input  wire logic wr_data,
   // Stored flag
   output logic      flag_reg
);

   logic flag_next;

   always_comb
   begin
      flag_next = flag_reg;
      if (own_evt)
      begin
         flag_next = EVT_VAL;
      end
      else if (USE_PWR && pwr_evt)
      begin
         flag_next = PWR_VAL;
      end
      else if (wr_en)
      begin
         flag_next = wr_data;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         flag_reg <= POR_VAL;
      end
      else
      begin
         flag_reg <= flag_next;
      end
   end

endmodule // rcf_flag_bit

// ---- logic/rcf_reset_cause.sv ----
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
// Reset-cause flag register with an APB slave port and one interrupt line.
// nrst is the power-on reset of this block; every other reset cause
// arrives as an event while the block keeps running, so the flags survive.
module rcf_reset_cause (
   // Clock and power-on reset
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Reset sources and stack faults from the core
   input  wire logic        stack_overflow_evt,
   input  wire logic        stack_underflow_evt,
   input  wire logic        reset_instr_evt,
   input  wire logic        brownout_evt,
   // Master-clear pin, active low, asynchronous
   input  wire logic        master_clear_pin_n,
   // Interrupt
   output logic             irq
);

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] off);
      addr_hit = (addr == off);
   endfunction

   function automatic logic addr_mapped(input logic [11:0] addr);
      addr_mapped = addr_hit(addr, rcf_pkg::OFF_CAUSE) ||
                    addr_hit(addr, rcf_pkg::OFF_IRQ_STAT) ||
                    addr_hit(addr, rcf_pkg::OFF_IRQ_MASK);
   endfunction

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic        pin_sync1_reg;
   logic        pin_sync2_reg;
   logic        pin_prev_reg;
   logic        pin_rst_evt;
   logic [7:0]  own_evt;
   logic [7:0]  cause_reg;
   logic [7:0]  irq_stat_reg;
   logic [7:0]  irq_stat_next;
   logic [7:0]  irq_mask_reg;
   logic [31:0] prdata_reg;
   logic        slverr_reg;
   logic        setup_phase;
   logic        wr_access;
   logic        wr_cause;
   logic        wr_irq_stat;
   logic        wr_irq_mask;
   logic [7:0]  rd_data;

   // ------------------------------------------------------------
   // Master-clear pin synchroniser and assertion edge
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pin_sync1_reg <= rcf_pkg::PIN_IDLE;
         pin_sync2_reg <= rcf_pkg::PIN_IDLE;
         pin_prev_reg  <= rcf_pkg::PIN_IDLE;
      end
      else
      begin
         pin_sync1_reg <= master_clear_pin_n;
         pin_sync2_reg <= pin_sync1_reg;
         pin_prev_reg  <= pin_sync2_reg;
      end
   end

   // One event per pin assertion; a pin held low does not keep re-clearing
   assign pin_rst_evt = pin_prev_reg & ~pin_sync2_reg;

   // ------------------------------------------------------------
   // Per-bit hardware events
   // ------------------------------------------------------------
   always_comb
   begin
      own_evt                              = 8'h00;
      own_evt[rcf_pkg::BIT_STACK_OVF]      = stack_overflow_evt;
      own_evt[rcf_pkg::BIT_STACK_UNF]      = stack_underflow_evt;
      own_evt[rcf_pkg::BIT_PIN_RST]        = pin_rst_evt;
      own_evt[rcf_pkg::BIT_RST_INSTR]      = reset_instr_evt;
      own_evt[rcf_pkg::BIT_BROWNOUT]       = brownout_evt;
   end

   // ------------------------------------------------------------
   // APB access qualifiers
   // ------------------------------------------------------------
   // Zero-wait slave: data is prepared in the setup cycle
   assign pready      = 1'b1;
   assign setup_phase = psel & ~penable;
   // Data live in the low byte, so its strobe alone gates a write
   assign wr_access   = psel & penable & pwrite & pstrb[0];
   assign wr_cause    = wr_access & addr_hit(paddr, rcf_pkg::OFF_CAUSE);
   assign wr_irq_stat = wr_access & addr_hit(paddr, rcf_pkg::OFF_IRQ_STAT);
   assign wr_irq_mask = wr_access & addr_hit(paddr, rcf_pkg::OFF_IRQ_MASK);

   // ------------------------------------------------------------
   // Reset-cause flags
   // ------------------------------------------------------------
   // Unimplemented positions get no flop and read as zero.
   // Brown-out is the only power event seen at run time; nrst covers power-on.
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_flag
         if (rcf_pkg::CAUSE_IMPL_MASK[gi])
         begin : g_impl
            rcf_flag_bit #(
               .POR_VAL (rcf_pkg::CAUSE_POR_VAL[gi]),
               .EVT_VAL (rcf_pkg::CAUSE_EVT_VAL[gi]),
               .PWR_VAL (rcf_pkg::CAUSE_POR_VAL[gi]),
               .USE_PWR (rcf_pkg::CAUSE_PWR_MASK[gi])
            ) u_flag (
               .sys_clk  (sys_clk),
               .nrst     (nrst),
               .own_evt  (own_evt[gi]),
               .pwr_evt  (brownout_evt),
               .wr_en    (wr_cause),
               .wr_data  (pwdata[gi]),
               .flag_reg (cause_reg[gi])
            );
         end
         else
         begin : g_unimpl
            assign cause_reg[gi] = 1'b0;
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Interrupt status and mask
   // ------------------------------------------------------------
   // A new event wins over a write-one-to-clear in the same cycle
   always_comb
   begin
      irq_stat_next = irq_stat_reg;
      if (wr_irq_stat)
      begin
         irq_stat_next = irq_stat_next & ~pwdata[7:0];
      end
      irq_stat_next = (irq_stat_next | own_evt) & rcf_pkg::IRQ_IMPL_MASK;
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         irq_stat_reg <= rcf_pkg::IRQ_STAT_RST;
      end
      else
      begin
         irq_stat_reg <= irq_stat_next;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         irq_mask_reg <= rcf_pkg::IRQ_MASK_RST;
      end
      else if (wr_irq_mask)
      begin
         irq_mask_reg <= pwdata[7:0] & rcf_pkg::IRQ_IMPL_MASK;
      end
   end

   assign irq = |(irq_stat_reg & irq_mask_reg);

   // ------------------------------------------------------------
   // APB read data and error
   // ------------------------------------------------------------
   always_comb
   begin
      rd_data = 8'h00;
      if (addr_hit(paddr, rcf_pkg::OFF_CAUSE))
      begin
         rd_data = cause_reg & rcf_pkg::CAUSE_IMPL_MASK;
      end
      else if (addr_hit(paddr, rcf_pkg::OFF_IRQ_STAT))
      begin
         rd_data = irq_stat_reg;
      end
      else if (addr_hit(paddr, rcf_pkg::OFF_IRQ_MASK))
      begin
         rd_data = irq_mask_reg;
      end
   end

   // Read data is captured in setup, so a flag event in the access cycle
   // shows on the next read, not this one.
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         prdata_reg <= 32'h0000_0000;
      end
      else if (setup_phase)
      begin
         prdata_reg <= {24'h00_0000, rd_data};
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         slverr_reg <= 1'b0;
      end
      else if (setup_phase)
      begin
         slverr_reg <= ~addr_mapped(paddr);
      end
   end

   assign prdata  = prdata_reg;
   assign pslverr = slverr_reg & psel & penable;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   stack_ovf_set_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      stack_overflow_evt
         || (cause_reg[rcf_pkg::BIT_STACK_OVF] && !brownout_evt
             && !(wr_cause && !pwdata[rcf_pkg::BIT_STACK_OVF]))
         |=> cause_reg[rcf_pkg::BIT_STACK_OVF])
      else $error("stack overflow flag lost before firmware clear");

   stack_unf_set_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      stack_underflow_evt ##1 !(wr_cause && !pwdata[rcf_pkg::BIT_STACK_UNF])
                              && !brownout_evt
         |=> cause_reg[rcf_pkg::BIT_STACK_UNF])
      else $error("stack underflow flag not held");

   unimpl_zero_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      psel && penable && !pwrite && addr_hit(paddr, rcf_pkg::OFF_CAUSE)
         |-> prdata[5:4] == 2'b00)
      else $error("unimplemented cause bits read nonzero");

   pin_clear_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      $fell(pin_sync2_reg) |=> !cause_reg[rcf_pkg::BIT_PIN_RST])
      else $error("pin reset did not clear its flag");

   instr_clear_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      reset_instr_evt |=> !cause_reg[rcf_pkg::BIT_RST_INSTR])
      else $error("reset instruction did not clear its flag");

   power_on_hold_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      $rose(cause_reg[rcf_pkg::BIT_POWER_ON])
         |-> $past(wr_cause) && $past(pwdata[rcf_pkg::BIT_POWER_ON]))
      else $error("power-on flag rose without a firmware write");

   brownout_flag_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      brownout_evt |=> !cause_reg[rcf_pkg::BIT_BROWNOUT]
                       ##1 ($past(wr_cause) || !cause_reg[rcf_pkg::BIT_BROWNOUT]))
      else $error("brown-out flag wrong after brown-out");

   brownout_vals_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      brownout_evt && !stack_overflow_evt && !stack_underflow_evt
         && !reset_instr_evt && !pin_rst_evt
         |=> (cause_reg & rcf_pkg::CAUSE_PWR_MASK) == rcf_pkg::CAUSE_POR_VAL
             && cause_reg[rcf_pkg::BIT_POWER_ON] == $past(cause_reg[rcf_pkg::BIT_POWER_ON]))
      else $error("brown-out left wrong flag values");

   hw_wins_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      wr_cause && pwdata[rcf_pkg::BIT_RST_INSTR] && reset_instr_evt
         |=> !cause_reg[rcf_pkg::BIT_RST_INSTR])
      else $error("firmware write beat reset instruction event");

   irq_raise_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      stack_overflow_evt && irq_mask_reg[rcf_pkg::BIT_STACK_OVF] && !wr_irq_mask
         |=> irq)
      else $error("unmasked event did not raise irq");

   // Only a firmware write may move the power-on flag; brown-out leaves it
   power_on_keep_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      !wr_cause
         |=> $stable(cause_reg[rcf_pkg::BIT_POWER_ON]))
      else $error("power-on flag changed without a firmware write");

   ovf_write_race_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      wr_cause && !pwdata[rcf_pkg::BIT_STACK_OVF] && stack_overflow_evt
         |=> cause_reg[rcf_pkg::BIT_STACK_OVF])
      else $error("firmware clear beat stack overflow event");

   strobe_ignore_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      psel && penable && pwrite && !pstrb[0] && own_evt == 8'h00
         |=> $stable(cause_reg))
      else $error("write without low strobe changed cause flags");

   // ------------------------------------------------------------
   // Checks on the bus and interrupt side
   // ------------------------------------------------------------
   cause_read_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      setup_phase && addr_hit(paddr, rcf_pkg::OFF_CAUSE)
         |=> prdata[7:0] == $past(cause_reg))
      else $error("cause read data differs from flags at setup");

   rdata_hold_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      !setup_phase
         |=> $stable(prdata))
      else $error("read data changed outside a setup cycle");

   bus_error_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      psel && penable
         |-> pslverr == !addr_mapped(paddr))
      else $error("slave error does not match address decode");

   stat_sticky_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      !wr_irq_stat
         |=> (irq_stat_reg & $past(irq_stat_reg)) == $past(irq_stat_reg))
      else $error("interrupt status bit dropped without a clear");

   stat_event_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      own_evt != 8'h00
         |=> (irq_stat_reg & $past(own_evt)) == $past(own_evt))
      else $error("event did not set its interrupt status bit");

   stat_clear_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      wr_irq_stat && own_evt == 8'h00
         |=> (irq_stat_reg & $past(pwdata[7:0])) == 8'h00)
      else $error("write of one did not clear interrupt status");

endmodule // rcf_reset_cause

// ---- dv/rcf_core_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Core-side reset sources and stack logic
// ----------------------------------------
module rcf_core_model (
   // Clock
   input  wire logic sys_clk,
   // Events toward the cause register
   output logic      stack_overflow_evt,
   output logic      stack_underflow_evt,
   output logic      reset_instr_evt,
   output logic      brownout_evt,
   // Pulled-up pin, so it reads high whenever nobody holds it down
   output logic      master_clear_pin_n
);
   initial
   begin
      {stack_overflow_evt, stack_underflow_evt, reset_instr_evt, brownout_evt} = 4'h0;
      master_clear_pin_n = 1'h1;
   end

   // One-cycle pulse: 0 overflow, 1 underflow, 2 instruction, 3 brown-out
   task automatic pulse(input int kind);
      @(posedge sys_clk);
      case (kind)
         0: stack_overflow_evt <= 1'h1;
         1: stack_underflow_evt <= 1'h1;
         2: reset_instr_evt <= 1'h1;
         default: brownout_evt <= 1'h1;
      endcase
      @(posedge sys_clk);
      {stack_overflow_evt, stack_underflow_evt, reset_instr_evt, brownout_evt} <= 4'h0;
   endtask

   task automatic press_pin(input int cycles);
      @(posedge sys_clk);
      master_clear_pin_n <= 1'h0;
      repeat (cycles) @(posedge sys_clk);
      master_clear_pin_n <= 1'h1;
   endtask
endmodule // rcf_core_model

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic        sys_clk;
   logic        nrst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic        ovf;
   logic        unf;
   logic        ins;
   logic        bo;
   logic        pin_n;
   logic        irq;
   logic [31:0] rd;
   logic        err;
   int          err_count;
   int          comparisons;
   int          cycles;

   rcf_reset_cause rcf_reset_cause_i (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .stack_overflow_evt(ovf),
      .stack_underflow_evt(unf), .reset_instr_evt(ins), .brownout_evt(bo),
      .master_clear_pin_n(pin_n), .irq(irq));
   rcf_core_model rcf_core_model_i (.sys_clk(sys_clk), .stack_overflow_evt(ovf),
      .stack_underflow_evt(unf), .reset_instr_evt(ins), .brownout_evt(bo),
      .master_clear_pin_n(pin_n));

   // ----------------------------------------
   // Clock, reset and hang guard
   // ----------------------------------------
   initial sys_clk = 1'h0;
   always #4 sys_clk = ~sys_clk;

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         complete_run();
      end
   end

   task automatic do_reset();
      nrst <= 1'h0;
      repeat (20) @(posedge sys_clk);
      nrst <= 1'h1;
   endtask

   // ----------------------------------------
   // Bus and compare helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Waits for pready as long as it takes; only the hang guard ends a stuck wait
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge sys_clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge sys_clk);
      penable <= 1'h1;
      do
      begin
         @(posedge sys_clk);
      end
      while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'h1, a, {24'h0, d}, 4'hf);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
      apb(1'h0, a, 32'h0, 4'hf);
      chk(rd, {24'h0, exp});
      chk({31'h0, err}, 32'h0);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      do_reset();
      chk({31'h0, pready}, 32'h1);
      rdchk(rcf_pkg::OFF_CAUSE, 8'h0c);
      rdchk(rcf_pkg::OFF_IRQ_STAT, 8'h00);
      rdchk(rcf_pkg::OFF_IRQ_MASK, 8'h00);
   endtask

   task automatic t_arm();
      wr(rcf_pkg::OFF_CAUSE, 8'hff);
      rdchk(rcf_pkg::OFF_CAUSE, 8'hcf);
      apb(1'h1, rcf_pkg::OFF_CAUSE, 32'h0, 4'he);
      rdchk(rcf_pkg::OFF_CAUSE, 8'hcf);
      // Upper data bits and upper strobes carry nothing
      apb(1'h1, rcf_pkg::OFF_CAUSE, 32'h5a5a_5a0f, 4'h1);
      rdchk(rcf_pkg::OFF_CAUSE, 8'h0f);
   endtask

   task automatic t_flags();
      wr(rcf_pkg::OFF_CAUSE, 8'h0f);
      rcf_core_model_i.pulse(0);
      rdchk(rcf_pkg::OFF_CAUSE, 8'h8f);
      rcf_core_model_i.pulse(1);
      rdchk(rcf_pkg::OFF_CAUSE, 8'hcf);
      wr(rcf_pkg::OFF_CAUSE, 8'h4f);
      rdchk(rcf_pkg::OFF_CAUSE, 8'h4f);
      wr(rcf_pkg::OFF_CAUSE, 8'h0f);
      rdchk(rcf_pkg::OFF_CAUSE, 8'h0f);
      rcf_core_model_i.pulse(2);
      rdchk(rcf_pkg::OFF_CAUSE, 8'h0b);
      wr(rcf_pkg::OFF_CAUSE, 8'h0f);
      rdchk(rcf_pkg::OFF_CAUSE, 8'h0f);
      rcf_core_model_i.press_pin(4);
      repeat (4) @(posedge sys_clk);
      rdchk(rcf_pkg::OFF_CAUSE, 8'h07);
      wr(rcf_pkg::OFF_CAUSE, 8'h0f);
      rdchk(rcf_pkg::OFF_CAUSE, 8'h0f);
      wr(rcf_pkg::OFF_CAUSE, 8'hc3);
      rcf_core_model_i.pulse(3);
      rdchk(rcf_pkg::OFF_CAUSE, 8'h0e);
   endtask

   // Event lands on the very edge that takes the write, and must win
   task automatic t_prio(input int kind, input logic [7:0] exp);
      wr(rcf_pkg::OFF_CAUSE, 8'h0f);
      fork
         wr(rcf_pkg::OFF_CAUSE, 8'h0f);
         begin
            @(posedge sys_clk);
            rcf_core_model_i.pulse(kind);
         end
      join
      rdchk(rcf_pkg::OFF_CAUSE, exp);
   endtask

   task automatic t_irq();
      wr(rcf_pkg::OFF_IRQ_STAT, 8'hff);
      rdchk(rcf_pkg::OFF_IRQ_STAT, 8'h00);
      wr(rcf_pkg::OFF_IRQ_MASK, 8'h80);
      rcf_core_model_i.pulse(1);
      @(posedge sys_clk);
      chk({31'h0, irq}, 32'h0);
      rcf_core_model_i.pulse(0);
      @(posedge sys_clk);
      chk({31'h0, irq}, 32'h1);
      rdchk(rcf_pkg::OFF_IRQ_STAT, 8'hc0);
      wr(rcf_pkg::OFF_IRQ_STAT, 8'h80);
      @(posedge sys_clk);
      chk({31'h0, irq}, 32'h0);
      rdchk(rcf_pkg::OFF_IRQ_STAT, 8'h40);
      apb(1'h0, 12'h00c, 32'h0, 4'hf);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
   endtask

   task automatic complete_run();
      if (err_count == 0 && comparisons > 0)
      begin
         $display("Result: passed");
      end
      else
      begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      t_reset();
      t_arm();
      t_flags();
      t_prio(0, 8'h8f);
      t_prio(2, 8'h0b);
      t_irq();
      t_reset();
      complete_run();
   end
endmodule // tb
